// *** hdl/psc_cfg.svh ***
/*
  Timing counts, widths and reset values of the passive serial
  configuration loader.
  Assumes a core clock of 125 MHz; every core cycle count is derived from it.
*/
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// core clock rate
`define PSC_CLK_MHZ 125

// power-up hold of the status line, longest time
`define PSC_T_POR_NS 5000
`define PSC_POR_CYC ((`PSC_T_POR_NS * `PSC_CLK_MHZ) / 1000)

// self-made status low pulse, least and longest time
`define PSC_T_STATUS_MIN_NS 10000
`define PSC_T_STATUS_MAX_NS 40000
`define PSC_ERR_CYC ((`PSC_T_STATUS_MIN_NS * `PSC_CLK_MHZ + 999) / 1000)

// load complete high to user mode on the internal clock, least and longest time
`define PSC_T_CD2UM_MIN_NS 2000
`define PSC_T_CD2UM_MAX_NS 8000
`define PSC_INIT_CYC ((`PSC_T_CD2UM_MIN_NS * `PSC_CLK_MHZ + 999) / 1000)

// user init clock periods to user mode
`define PSC_INIT_USER_CLKS 40

// counter widths
`define PSC_CNT_W 12
`define PSC_UCNT_W 6

// serial byte width and sync lane count
`define PSC_BYTE_W 8
`define PSC_SYNC_W 6

// reset values
`define PSC_SYNC_RST 6'h00
`define PSC_BYTE_RST 8'h00

// expected first byte of a bitstream
`define PSC_SYNC_BYTE 8'hA5

`endif

// *** hdl/psc_pkg.sv ***
/*
  Types of the passive serial configuration loader.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package psc_pkg;

  // configuration stages, gray coded along the usual path
  typedef enum logic [2:0] {
    PSC_POR  = 3'h0,
    PSC_RST  = 3'h1,
    PSC_CFG  = 3'h3,
    PSC_WAIT = 3'h2,
    PSC_INIT = 3'h6,
    PSC_USER = 3'h7,
    PSC_ERR  = 3'h5
  } psc_state_t;

endpackage : psc_pkg

`default_nettype wire

// *** hdl/psc_sync.sv ***
/*
  Two flip-flop level synchroniser, one lane per bit.
  Assumes each input is a level that stays for several core cycles.
*/
`default_nettype none
`include "psc_cfg.svh"

module psc_sync #(
  parameter int WIDTH = `PSC_SYNC_W
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // synchronous reset
  input wire logic [WIDTH-1:0] i_async, // levels from other domains
  output logic [WIDTH-1:0] o_sync // synchronised levels
);

  logic [WIDTH-1:0] meta;

  // first stage, read only by the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= WIDTH'(`PSC_SYNC_RST);
    end else begin
      meta <= i_async;
    end
  end

  // second stage
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sync <= WIDTH'(`PSC_SYNC_RST);
    end else begin
      o_sync <= meta;
    end
  end

endmodule : psc_sync

`default_nettype wire

// *** hdl/psc_loader.sv ***
/*
  Device side of passive serial configuration: serial capture on the
  configuration clock, chain hand-off, status and load complete lines,
  reset, error, initialization and user mode sequencing.
  Assumes open-drain pins are resolved outside; serial configuration
  clock idles from status release until the first data edge.
*/
// What this block does
// - first device enabled; finished device drives chain enable out low
// - next device accepts bits on its first clock edge once enabled
// - initialization waits until shared load complete line reads high
// - detected error pulls status low, resetting the whole chain
// - with auto-restart, status released within 40 us after error
// - broadcast: all enables tied active, all load same stream together
// - request falling drives load complete low within 200 ns
// - request falling drives status low within 200 ns
// - self-made status low pulse lasts 10 to 40 us
// - request rising releases status within 1 us
// - user mode 2 to 8 us after load complete, or 40 user clocks
// - power-up holds status low at most 5 us, then releases
// - load complete held low from power-up until all data received
// - data sampled on rising clock edge, each byte least bit first
// - reset while request low, or status low before user mode; data taken only when both high
`default_nettype none
`include "psc_cfg.svh"

module psc_loader #(
  parameter int BITSTREAM_BITS = 1024, // bits this device takes
  parameter logic [7:0] SYNC_BYTE = `PSC_SYNC_BYTE // expected first byte
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // synchronous reset, power-up
  input wire logic i_serial_config_clock, // link clock from host
  input wire logic i_serial_config_bit, // serial data pin
  input wire logic i_chain_enable_in_n, // chain enable in, low active
  output logic o_chain_enable_out_n, // chain enable out, low active
  input wire logic i_config_request_n, // configuration request pin
  input wire logic i_status_error_line_n, // status line level
  output logic o_status_error_line_n, // status line drive value
  output logic o_status_error_line_n_oe_n, // low while pulling status
  input wire logic i_load_complete, // load complete line level
  output logic o_load_complete, // load complete drive value
  output logic o_load_complete_oe_n, // low while pulling load complete
  input wire logic i_user_init_clock, // user init clock pin
  input wire logic i_use_user_clock, // strap: init on user clock
  input wire logic i_auto_restart, // strap: restart after error
  output logic [7:0] o_cfg_byte, // last assembled byte, link domain
  output logic o_cfg_byte_stb, // byte valid, link domain
  output logic o_user_mode // device in user mode
);

  localparam int BIT_W = $clog2(BITSTREAM_BITS + 1);
  localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(BITSTREAM_BITS - 1);
  localparam logic [11:0] POR_LAST = 12'(`PSC_POR_CYC - 1);
  localparam logic [11:0] ERR_LAST = 12'(`PSC_ERR_CYC - 1);
  localparam logic [11:0] INIT_LAST = 12'(`PSC_INIT_CYC - 1);
  localparam logic [5:0] UCLK_LAST = 6'(`PSC_INIT_USER_CLKS - 1);
  localparam logic [11:0] CNT_MAX = 12'hFFF;

  // stage and its successor
  psc_pkg::psc_state_t state;
  psc_pkg::psc_state_t next_state;

  // link domain state
  logic link_hold; // core flop, clears the link logic
  logic lnk_done;
  logic lnk_err;
  logic lnk_first;
  logic lnk_accept;
  logic [2:0] lnk_pos;
  logic [7:0] lnk_shift;
  logic [BIT_W-1:0] lnk_bits;
  logic lnk_byte_end; // eighth bit of a byte on this edge
  logic [7:0] lnk_next_byte; // byte as it stands after this edge

  // core domain state
  logic [5:0] sync_in;
  logic [5:0] sync_out;
  logic req_s;
  logic stat_s;
  logic lc_s;
  logic uclk_s;
  logic done_s;
  logic err_s;
  logic uclk_prev;
  logic uclk_rise;
  logic [11:0] cnt;
  logic [5:0] ucnt;
  logic init_end;
  logic next_drive_st;
  logic next_drive_lc;
  logic drive_st;
  logic drive_lc;

  // ---------------- link domain ----------------

  // enable sampled directly: the previous device drives it from this clock
  assign lnk_accept = !i_chain_enable_in_n && !lnk_done && !lnk_err;

  // byte completed by the current bit, least bit first
  assign lnk_next_byte = {i_serial_config_bit, lnk_shift[7:1]};
  assign lnk_byte_end = lnk_accept && lnk_pos == 3'h7;

  // serial shift, least bit of each byte first
  always_ff @(posedge i_serial_config_clock or posedge link_hold) begin
    if (link_hold) begin
      lnk_shift <= `PSC_BYTE_RST;
      lnk_pos <= 3'h0;
    end else if (lnk_accept) begin
      lnk_shift <= {i_serial_config_bit, lnk_shift[7:1]};
      lnk_pos <= lnk_pos + 3'h1;
    end
  end

  // byte output and its strobe
  always_ff @(posedge i_serial_config_clock or posedge link_hold) begin
    if (link_hold) begin
      o_cfg_byte <= `PSC_BYTE_RST;
      o_cfg_byte_stb <= 1'b0;
    end else if (lnk_byte_end) begin
      o_cfg_byte <= lnk_next_byte;
      o_cfg_byte_stb <= 1'b1;
    end else begin
      o_cfg_byte_stb <= 1'b0;
    end
  end

  // first byte check, a mismatch is an error
  always_ff @(posedge i_serial_config_clock or posedge link_hold) begin
    if (link_hold) begin
      lnk_first <= 1'b1;
      lnk_err <= 1'b0;
    end else if (lnk_byte_end) begin
      lnk_first <= 1'b0;
      if (lnk_first && lnk_next_byte != SYNC_BYTE) begin
        lnk_err <= 1'b1;
      end
    end
  end

  // bit count and end of this device's data
  always_ff @(posedge i_serial_config_clock or posedge link_hold) begin
    if (link_hold) begin
      lnk_bits <= '0;
      lnk_done <= 1'b0;
    end else if (lnk_accept) begin
      lnk_bits <= lnk_bits + BIT_W'(1);
      if (lnk_bits == LAST_BIT) begin
        lnk_done <= 1'b1;
      end
    end
  end

  // hand-off to the next device in the chain
  assign o_chain_enable_out_n = !lnk_done;

  // ---------------- core domain ----------------

  // pins and link levels into the core clock
  assign sync_in = {i_config_request_n, i_status_error_line_n, i_load_complete,
                    i_user_init_clock, lnk_done, lnk_err};

  psc_sync #(
    .WIDTH(6)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  assign req_s = sync_out[5];
  assign stat_s = sync_out[4];
  assign lc_s = sync_out[3];
  assign uclk_s = sync_out[2];
  assign done_s = sync_out[1];
  assign err_s = sync_out[0];

  // user init clock edge detect on the synchronised level
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      uclk_prev <= 1'b0;
    end else begin
      uclk_prev <= uclk_s;
    end
  end

  assign uclk_rise = uclk_s && !uclk_prev;

  // end of initialization, internal timer or user clock periods
  assign init_end = i_use_user_clock ? (uclk_rise && ucnt == UCLK_LAST)
                                     : (cnt == INIT_LAST);

  // stage sequencing
  always_comb begin
    next_state = state;
    case (state)
      psc_pkg::PSC_POR: begin
        if (cnt == POR_LAST) begin
          next_state = psc_pkg::PSC_RST;
        end
      end
      psc_pkg::PSC_RST: begin
        if (req_s && stat_s) begin
          next_state = psc_pkg::PSC_CFG;
        end
      end
      psc_pkg::PSC_CFG: begin
        if (!req_s || !stat_s) begin
          next_state = psc_pkg::PSC_RST;
        end else if (err_s) begin
          next_state = psc_pkg::PSC_ERR;
        end else if (done_s) begin
          next_state = psc_pkg::PSC_WAIT;
        end
      end
      psc_pkg::PSC_WAIT: begin
        if (!req_s || !stat_s) begin
          next_state = psc_pkg::PSC_RST;
        end else if (lc_s) begin
          next_state = psc_pkg::PSC_INIT;
        end
      end
      psc_pkg::PSC_INIT: begin
        if (!req_s || !stat_s) begin
          next_state = psc_pkg::PSC_RST;
        end else if (init_end) begin
          next_state = psc_pkg::PSC_USER;
        end
      end
      psc_pkg::PSC_USER: begin
        if (!req_s) begin
          next_state = psc_pkg::PSC_RST;
        end
      end
      psc_pkg::PSC_ERR: begin
        if (!req_s) begin
          next_state = psc_pkg::PSC_RST;
        end else if (cnt == ERR_LAST && i_auto_restart) begin
          next_state = psc_pkg::PSC_RST;
        end
      end
      default: begin
        next_state = psc_pkg::PSC_POR;
      end
    endcase
  end

  // stage register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= psc_pkg::PSC_POR;
    end else begin
      state <= next_state;
    end
  end

  // stage timer, restarts on each stage change, saturates
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= 12'h000;
    end else if (next_state != state) begin
      cnt <= 12'h000;
    end else if (cnt != CNT_MAX) begin
      cnt <= cnt + 12'h001;
    end
  end

  // user init clock period count during initialization
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ucnt <= 6'h00;
    end else if (state != psc_pkg::PSC_INIT) begin
      ucnt <= 6'h00;
    end else if (uclk_rise) begin
      ucnt <= ucnt + 6'h01;
    end
  end

  // stages in which the link logic is held clear
  function automatic logic holds_link(input psc_pkg::psc_state_t s);
    return s == psc_pkg::PSC_POR || s == psc_pkg::PSC_RST || s == psc_pkg::PSC_ERR;
  endfunction : holds_link

  // link logic held clear through reset, power-up and error
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      link_hold <= 1'b1;
    end else begin
      link_hold <= holds_link(next_state);
    end
  end

  // status pulled low at power-up, on request low and on own error
  assign next_drive_st = next_state == psc_pkg::PSC_POR ||
                         next_state == psc_pkg::PSC_ERR ||
                         (next_state == psc_pkg::PSC_RST && !req_s);

  // load complete low until this device has all its data
  assign next_drive_lc = holds_link(next_state) ||
                         next_state == psc_pkg::PSC_CFG;

  // registered status drive
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      drive_st <= 1'b1;
    end else begin
      drive_st <= next_drive_st;
    end
  end

  // registered load complete drive
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      drive_lc <= 1'b1;
    end else begin
      drive_lc <= next_drive_lc;
    end
  end

  // open-drain pins only ever pull low
  assign o_status_error_line_n = 1'b0;
  assign o_load_complete = 1'b0;

  // pull enables, low while pulling
  assign o_status_error_line_n_oe_n = !drive_st;
  assign o_load_complete_oe_n = !drive_lc;

  // user mode flag
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_user_mode <= 1'b0;
    end else begin
      o_user_mode <= next_state == psc_pkg::PSC_USER;
    end
  end

endmodule : psc_loader

`default_nettype wire

// *** dv/psc_loader_assertions.sv ***
/* Checker of psc_loader port timing, bound to every loader instance.
   Assumes open-drain lines are resolved outside and fed back. */
`default_nettype none
module psc_chk (
  input wire logic i_clk, // core clock
  input wire logic i_rst, // sync reset
  input wire logic i_config_request_n, // request pin
  input wire logic i_status_error_line_n, // status line level
  input wire logic i_load_complete, // load line level
  input wire logic i_use_user_clock, // init clock strap
  input wire logic i_auto_restart, // restart strap
  input wire logic o_status_error_line_n_oe_n, // status pull
  input wire logic o_load_complete_oe_n, // load pull
  input wire logic o_chain_enable_out_n, // chain out
  input wire logic o_user_mode // user mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] hi_cnt; // cycles with load line, request and status high
  logic [12:0] lo_cnt; // cycles of own status pull with request high
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // saturating run-length counters
  always_ff @(posedge i_clk) begin
    if (i_rst || !(i_load_complete && i_config_request_n && i_status_error_line_n)) begin
      hi_cnt <= 13'h0;
    end else if (hi_cnt != 13'h1FFF) begin
      hi_cnt <= hi_cnt + 13'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst || o_status_error_line_n_oe_n || !i_config_request_n) begin
      lo_cnt <= 13'h0;
    end else if (lo_cnt != 13'h1FFF) begin
      lo_cnt <= lo_cnt + 13'h1;
    end
  end
  a_req_status_low: assert property (
    $fell(i_config_request_n) |-> ##[1:25] !o_status_error_line_n_oe_n)
    else $error("status not pulled after request");
  a_req_load_low: assert property (
    $fell(i_config_request_n) |-> ##[1:25] !o_load_complete_oe_n)
    else $error("load line not pulled after request");
  a_req_user_drop: assert property (
    $fell(i_config_request_n) |-> ##[1:25] !o_user_mode)
    else $error("user mode kept during request");
  a_req_release: assert property (
    $rose(i_config_request_n) |-> ##[1:125] o_status_error_line_n_oe_n)
    else $error("status not released after request");
  a_user_min: assert property (
    $rose(o_user_mode) && !i_use_user_clock |-> hi_cnt >= 13'h0F0)
    else $error("user mode too early");
  a_user_max: assert property (
    hi_cnt == 13'h3E8 && !i_use_user_clock |-> o_user_mode)
    else $error("user mode too late");
  a_err_pulse_min: assert property (
    $rose(o_status_error_line_n_oe_n) && lo_cnt > 13'h2BC |-> lo_cnt >= 13'h4E2)
    else $error("error pulse too short");
  a_err_pulse_max: assert property (
    i_auto_restart |-> lo_cnt <= 13'h1388)
    else $error("error pulse too long");
  a_load_after_done: assert property (
    $rose(o_load_complete_oe_n) |-> !o_chain_enable_out_n)
    else $error("load line released before all data");
  c_user: cover property ($rose(o_user_mode));
  c_chain: cover property ($fell(o_chain_enable_out_n));
  c_error: cover property ($rose(o_status_error_line_n_oe_n) && lo_cnt > 13'h2BC);
endmodule : psc_chk
bind psc_loader psc_chk chk (.*);
`default_nettype wire

// *** dv/psc_host.sv ***
/* Host model: request pin and serial byte stream.
   Assumes the bench calls its tasks and paces them with the core clock. */
`default_nettype none
module psc_host (
  input wire logic i_clk, // core clock, paces the request pin
  output logic o_sclk, // serial clock, still outside frames
  output logic o_sbit, // serial data, always driven
  output logic o_req_n // configuration request
);
  timeunit 1ns;
  timeprecision 1ps;
  // defined levels from time zero and after loading
  initial begin
    o_sclk = 1'b0;
    o_sbit = 1'b0;
    o_req_n = 1'b1;
  end
  // one byte on a 12 ns clock, least bit first, data held after
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      o_sbit <= b[i];
      #6 o_sclk <= 1'b1;
      #6 o_sclk <= 1'b0;
    end
  endtask : send_byte
  // request pin level on a core edge
  task automatic set_req(input logic v);
    @(posedge i_clk) o_req_n <= v;
  endtask : set_req
endmodule : psc_host
`default_nettype wire

// *** dv/tb_psc_loader.sv ***
/* Self-checking bench of psc_loader with a host model.
   Assumes the host model and the bound checker are compiled first. */
`default_nettype none
module tb_psc_loader;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst, ucl, chin_n, ext_ld_n, ext_st_n, use_uc, auto_rs;
  logic sclk, sbit, req_n, ceo_n, st_oe_n, ld_oe_n, st_v, ld_v, stb, um;
  logic [7:0] byt;
  wire logic st_line = st_oe_n & ext_st_n; // pulled up unless a device pulls
  wire logic ld_line = ld_oe_n & ext_ld_n; // shared with another device
  wire logic [3:0] watch = {um, ceo_n, ld_oe_n, st_oe_n};
  int failures, samples_checked, n;
  psc_host host (.i_clk(i_clk), .o_sclk(sclk), .o_sbit(sbit), .o_req_n(req_n));
  psc_loader #(.BITSTREAM_BITS(32)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_serial_config_clock(sclk),
    .i_serial_config_bit(sbit), .i_chain_enable_in_n(chin_n),
    .o_chain_enable_out_n(ceo_n), .i_config_request_n(req_n),
    .i_status_error_line_n(st_line), .o_status_error_line_n(st_v),
    .o_status_error_line_n_oe_n(st_oe_n), .i_load_complete(ld_line),
    .o_load_complete(ld_v), .o_load_complete_oe_n(ld_oe_n),
    .i_user_init_clock(ucl), .i_use_user_clock(use_uc), .i_auto_restart(auto_rs),
    .o_cfg_byte(byt), .o_cfg_byte_stb(stb), .o_user_mode(um));
  // core clock 8 ns, user init clock 80 ns
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  initial begin
    ucl = 1'b0;
    forever #40 ucl = ~ucl;
  end
  task automatic end_of_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // bounded wait for one watched output, cycles left in n
  task automatic wait_bit(input int idx, input logic v, input int lim);
    n = 0;
    while (watch[idx] !== v && n < lim) begin
      @(posedge i_clk);
      n++;
    end
  endtask : wait_bit
  // good 32-bit stream, every byte checked as it lands
  task automatic stream;
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      b = (i == 0) ? 8'hA5 : 8'h3C + 8'(i);
      host.send_byte(b);
      check("cfg byte", b, byt);
      check("byte strobe", 8'h01, {7'h00, stb});
    end
  endtask : stream
  task automatic t_power;
    wait_bit(0, 1'b1, 2000);
    check("power-up release", 8'h01, {7'h00, n <= 640});
    check("load drive", 8'h00, {7'h00, ld_oe_n});
    check("status drive value", 8'h00, {7'h00, st_v});
    check("load drive value", 8'h00, {7'h00, ld_v});
  endtask : t_power
  task automatic t_chain;
    @(posedge i_clk) ext_ld_n <= 1'b0;
    repeat (5000) @(posedge i_clk);
    host.send_byte(8'hA5);
    check("refused strobe", 8'h00, {7'h00, stb});
    @(posedge i_clk) chin_n <= 1'b0;
    @(posedge i_clk);
    stream();
    check("chain out", 8'h00, {7'h00, ceo_n});
    wait_bit(1, 1'b1, 50);
    check("load release", 8'h01, {7'h00, n < 50});
    repeat (400) @(posedge i_clk);
    check("held by line", 8'h00, {7'h00, um});
    @(posedge i_clk) ext_ld_n <= 1'b1;
    wait_bit(3, 1'b1, 1100);
    check("init time", 8'h01, {7'h00, n >= 250 && n <= 1000});
    repeat (800) @(posedge i_clk);
    check("user mode kept", 8'h01, {7'h00, um});
  endtask : t_chain
  task automatic t_reconf;
    host.set_req(1'b0);
    wait_bit(0, 1'b0, 30);
    check("status pull time", 8'h01, {7'h00, n <= 25});
    check("load pull", 8'h00, {7'h00, ld_oe_n});
    repeat (1000) @(posedge i_clk);
    check("user mode left", 8'h00, {7'h00, um});
    host.set_req(1'b1);
    wait_bit(0, 1'b1, 130);
    check("status release", 8'h01, {7'h00, n <= 125});
    repeat (10) @(posedge i_clk);
    check("chain out cleared", 8'h01, {7'h00, ceo_n});
  endtask : t_reconf
  task automatic t_error;
    repeat (5000) @(posedge i_clk);
    // a good first byte, then another device pulls status: link must restart
    host.send_byte(8'hA5);
    @(posedge i_clk) ext_st_n <= 1'b0;
    repeat (200) @(posedge i_clk);
    check("own status kept off", 8'h01, {7'h00, st_oe_n});
    @(posedge i_clk) ext_st_n <= 1'b1;
    repeat (130) @(posedge i_clk);
    @(posedge i_clk) use_uc <= 1'b1;
    host.send_byte(8'h5A);
    wait_bit(0, 1'b0, 50);
    check("error pull", 8'h00, {7'h00, st_oe_n});
    wait_bit(0, 1'b1, 6000);
    check("error pulse", 8'h01, {7'h00, n >= 1240 && n <= 5000});
    check("chain out kept", 8'h01, {7'h00, ceo_n});
    repeat (125) @(posedge i_clk);
    stream();
    wait_bit(3, 1'b1, 600);
    check("user clock init", 8'h01, {7'h00, n >= 390 && n <= 430});
  endtask : t_error
  task automatic t_hold;
    host.set_req(1'b0);
    repeat (1000) @(posedge i_clk);
    @(posedge i_clk) auto_rs <= 1'b0;
    host.set_req(1'b1);
    repeat (5000) @(posedge i_clk);
    host.send_byte(8'h00);
    repeat (6000) @(posedge i_clk);
    check("error held", 8'h00, {7'h00, st_oe_n});
    host.set_req(1'b0);
    repeat (1000) @(posedge i_clk);
    host.set_req(1'b1);
    @(posedge i_clk) auto_rs <= 1'b1;
    wait_bit(0, 1'b1, 130);
    check("release after pulse", 8'h01, {7'h00, n <= 125});
  endtask : t_hold
  // reset, then the scenarios in turn
  initial begin
    i_rst = 1'b1;
    chin_n = 1'b1;
    ext_ld_n = 1'b1;
    use_uc = 1'b0;
    auto_rs = 1'b1;
    ext_st_n = 1'b1;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_power();
    t_chain();
    t_reconf();
    t_error();
    t_hold();
    end_of_test();
  end
  // hang guard, well beyond the expected run of about 250 us
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule : tb_psc_loader
`default_nettype wire
